/* hdl/uirc_codec.sv */
// Top level of the UART / infrared pulse codec: encoder, decoder, reset filter.
// Assumes all pins synchronous to ref_clk; bit_clock_in runs at 16x the baud rate.
`timescale 1ns/1ps
`default_nettype none
module uirc_codec (
    // System clock and reset pin
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Bit clock pin
    input  wire logic bit_clock_in,
    // Host serial side
    input  wire logic host_tx_in,
    output logic      host_rx_out,
    // Infrared transceiver side
    input  wire logic ir_pulse_in,
    output logic      ir_pulse_out
);
    import uirc_pkg::*;

    // Reset noise filter
    logic [RST_FILT_CYC-1:0] rst_hist;
    logic [RST_FILT_CYC-1:0] next_rst_hist;
    logic                    in_reset;
    logic                    next_in_reset;

    always_comb begin
        next_rst_hist = {rst_hist[RST_FILT_CYC-2:0], rst_n};
        next_in_reset = in_reset;
        if (rst_hist == '0) begin
            next_in_reset = 1'b1;
        end else if (&rst_hist) begin
            next_in_reset = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        rst_hist <= next_rst_hist;
        in_reset <= next_in_reset;
    end

    // Bit clock edge to one-cycle tick
    logic bclk_q;
    logic next_bclk_q;
    logic tick;
    assign tick = bit_clock_in && !bclk_q;

    // Held high in reset so a clock already high gives no false tick
    always_comb begin
        next_bclk_q = in_reset ? 1'b1 : bit_clock_in;
    end

    always_ff @(posedge ref_clk) begin
        bclk_q <= next_bclk_q;
    end

    function automatic logic last_bit(input logic [3:0] phase, input logic [3:0] bits);
        last_bit = (phase == 4'hf) && (bits == 4'(FRAME_BITS - 1));
    endfunction : last_bit

    // Encoder
    uirc_state_t enc_state;
    uirc_state_t next_enc_state;
    logic [3:0]  enc_phase;
    logic [3:0]  next_enc_phase;
    logic [3:0]  enc_bits;
    logic [3:0]  next_enc_bits;
    logic        enc_level;
    logic        next_enc_level;
    logic        next_ir_out;
    logic [7:0]  lim_cnt;
    logic [7:0]  next_lim_cnt;

    always_comb begin
        next_enc_state = enc_state;
        next_enc_phase = enc_phase;
        next_enc_bits  = enc_bits;
        next_enc_level = enc_level;
        next_ir_out    = ir_pulse_out;
        next_lim_cnt   = ir_pulse_out ? 8'(lim_cnt + 1'b1) : 8'h00;
        case (enc_state)
            UIRC_IDLE: begin
                if (tick && !host_tx_in) begin
                    next_enc_state = UIRC_BUSY;
                    next_enc_phase = 4'h1;
                    next_enc_bits  = 4'h0;
                    next_enc_level = 1'b0;
                end
            end
            UIRC_BUSY: begin
                if (tick) begin
                    next_enc_phase = 4'(enc_phase + 1'b1);
                    if (enc_phase == ENC_PULSE_START && !enc_level) begin
                        next_ir_out = 1'b1;
                    end else if (enc_phase == ENC_PULSE_END) begin
                        next_ir_out = 1'b0;
                    end
                    if (last_bit(enc_phase, enc_bits)) begin
                        next_enc_state = UIRC_IDLE;
                    end else if (enc_phase == 4'hf) begin
                        next_enc_bits  = 4'(enc_bits + 1'b1);
                        next_enc_level = host_tx_in;
                    end
                end
            end
            default: begin
                next_enc_state = UIRC_IDLE;
            end
        endcase
        if (ir_pulse_out && lim_cnt >= 8'(LIM_CYC - 1)) begin
            next_ir_out = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (in_reset) begin
            enc_state    <= UIRC_IDLE;
            enc_phase    <= 4'h0;
            enc_bits     <= 4'h0;
            enc_level    <= 1'b1;
            ir_pulse_out <= IR_RESET_LEVEL;
            lim_cnt      <= 8'h00;
        end else begin
            enc_state    <= next_enc_state;
            enc_phase    <= next_enc_phase;
            enc_bits     <= next_enc_bits;
            enc_level    <= next_enc_level;
            ir_pulse_out <= next_ir_out;
            lim_cnt      <= next_lim_cnt;
        end
    end

    // Decoder
    uirc_state_t dec_state;
    uirc_state_t next_dec_state;
    logic [3:0]  dec_phase;
    logic [3:0]  next_dec_phase;
    logic [3:0]  dec_bits;
    logic [3:0]  next_dec_bits;
    logic        low_seen;
    logic        next_low_seen;
    logic        pend_valid;
    logic        next_pend_valid;
    uirc_bit_t   pend_bit;
    uirc_bit_t   next_pend_bit;
    logic        buf_in_ready;

    always_comb begin
        next_dec_state  = dec_state;
        next_dec_phase  = dec_phase;
        next_dec_bits   = dec_bits;
        next_low_seen   = low_seen;
        next_pend_valid = pend_valid && !buf_in_ready;
        next_pend_bit   = pend_bit;
        case (dec_state)
            UIRC_IDLE: begin
                if (tick && !ir_pulse_in) begin
                    next_dec_state = UIRC_BUSY;
                    next_dec_phase = 4'h1;
                    next_dec_bits  = 4'h0;
                    next_low_seen  = 1'b1;
                end
            end
            UIRC_BUSY: begin
                if (tick) begin
                    next_dec_phase = 4'(dec_phase + 1'b1);
                    if (!ir_pulse_in) begin
                        next_low_seen = 1'b1;
                    end
                    if (dec_phase == DEC_LATCH_PHASE) begin
                        next_pend_valid     = 1'b1;
                        next_pend_bit.level = ir_pulse_in && !low_seen;
                        next_low_seen       = 1'b0;
                    end
                    if (last_bit(dec_phase, dec_bits)) begin
                        next_dec_state = UIRC_IDLE;
                    end else if (dec_phase == 4'hf) begin
                        next_dec_bits = 4'(dec_bits + 1'b1);
                    end
                end
            end
            default: begin
                next_dec_state = UIRC_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (in_reset) begin
            dec_state  <= UIRC_IDLE;
            dec_phase  <= 4'h0;
            dec_bits   <= 4'h0;
            low_seen   <= 1'b0;
            pend_valid <= 1'b0;
            pend_bit   <= '{level: 1'b1};
        end else begin
            dec_state  <= next_dec_state;
            dec_phase  <= next_dec_phase;
            dec_bits   <= next_dec_bits;
            low_seen   <= next_low_seen;
            pend_valid <= next_pend_valid;
            pend_bit   <= next_pend_bit;
        end
    end

    // Two-entry buffer between decoder and host output stage
    uirc_bit_t  buf_out;
    logic       buf_out_valid;
    logic       buf_out_ready;

    uirc_fifo #(
        .WIDTH ($bits(uirc_bit_t)),
        .DEPTH (BUF_DEPTH)
    ) u_rx_buf (
        .ref_clk   (ref_clk),
        .clr       (in_reset),
        .in_valid  (pend_valid),
        .in_ready  (buf_in_ready),
        .in_data   (pend_bit),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out)
    );

    // Host output stage holds each level for one full bit time
    logic [3:0] hold_cnt;
    logic [3:0] next_hold_cnt;
    logic       next_rx_out;

    assign buf_out_ready = tick && (hold_cnt == 4'h0);

    always_comb begin
        next_hold_cnt = hold_cnt;
        next_rx_out   = host_rx_out;
        if (tick) begin
            if (hold_cnt != 4'h0) begin
                next_hold_cnt = 4'(hold_cnt - 1'b1);
            end else if (buf_out_valid) begin
                next_rx_out   = buf_out.level;
                next_hold_cnt = 4'(BIT_TICKS - 1);
            end else begin
                next_rx_out   = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (in_reset) begin
            hold_cnt    <= 4'h0;
            host_rx_out <= RX_RESET_LEVEL;
        end else begin
            hold_cnt    <= next_hold_cnt;
            host_rx_out <= next_rx_out;
        end
    end
endmodule : uirc_codec
`default_nettype wire

/* hdl/uirc_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a synchronous active-high clear from the owner.
`timescale 1ns/1ps
`default_nettype none
module uirc_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 2
) (
    // Clock and clear
    input  wire logic             ref_clk,
    input  wire logic             clr,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = PW + 1;
    localparam logic [PW:0] FULL_CNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [PW:0]      next_count;
    logic             push;
    logic             pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : bump

    assign in_ready  = (count != FULL_CNT);
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
        next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
        next_count  = count;
        if (push && !pop) begin
            next_count = CW'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = CW'(count - 1'b1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clr) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule : uirc_fifo
`default_nettype wire

/* hdl/uirc_pkg.sv */
// Constants and types for the UART / infrared pulse codec.
// Assumes one 25 MHz system clock; the 16x bit clock arrives as a pin.
package uirc_pkg;
    // System clock
    localparam int CLK_HZ          = 25000000;
    // Bit clock ticks per serial bit, and bits per frame (start, 8 data, stop)
    localparam int BIT_TICKS       = 16;
    localparam int DATA_BITS       = 8;
    localparam int FRAME_BITS      = DATA_BITS + 2;
    // Encoder pulse placement in bit clock ticks
    localparam logic [3:0] ENC_PULSE_START = 4'h7;
    localparam logic [3:0] ENC_PULSE_TICKS = 4'h3;
    localparam logic [3:0] ENC_PULSE_END   = ENC_PULSE_START + ENC_PULSE_TICKS;
    // Decoder: phase at which a bit's level is decided
    localparam logic [3:0] DEC_LATCH_PHASE = 4'h3;
    // Pulse-width limiter: 4.00 us, longest time rounds down
    localparam int LIM_NS          = 4000;
    localparam int LIM_CYC         = (LIM_NS * (CLK_HZ / 1000000)) / 1000;
    // Reset noise filter length in system clocks
    localparam int RST_FILT_CYC    = 4;
    // Reset levels of the outputs
    localparam logic RX_RESET_LEVEL = 1'b1;
    localparam logic IR_RESET_LEVEL = 1'b0;
    // Buffer geometry
    localparam int BUF_DEPTH       = 2;

    // One decoded bit travelling toward the host output stage
    typedef struct packed {
        logic level;
    } uirc_bit_t;

    typedef enum logic [0:0] {
        UIRC_IDLE = 1'b0,
        UIRC_BUSY = 1'b1
    } uirc_state_t;
endpackage : uirc_pkg

/* tb/tb_top.sv */
// Testbench for the UART / infrared pulse codec.
// Assumes uirc_far drives the pins; the checker is bound below.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import uirc_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        bit_clock_in, host_tx_in, ir_pulse_in, host_rx_out, ir_pulse_out;
    logic        bc_q    = 1'b0;
    logic [15:0] got, rgot;
    logic [31:0] seed    = 32'h00014a4f;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          tk  = 255;
    int          rk  = 255;
    int          hi  = 0;
    uirc_far far_inst (.ref_clk(ref_clk), .bit_clock_in(bit_clock_in), .host_tx_in(host_tx_in),
                       .ir_pulse_in(ir_pulse_in));
    uirc_codec uirc_codec_inst (.ref_clk(ref_clk), .rst_n(rst_n), .bit_clock_in(bit_clock_in),
                                .host_tx_in(host_tx_in), .host_rx_out(host_rx_out),
                                .ir_pulse_in(ir_pulse_in), .ir_pulse_out(ir_pulse_out));
    always #20 ref_clk = !ref_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction : xs
    function automatic logic [31:0] exp_frame(input logic [7:0] b);
        return {22'h0, 1'b1, b, 1'b0};
    endfunction : exp_frame
    function automatic logic [31:0] exp_width(input int h);
        return (6 * h < LIM_CYC) ? 32'(6 * h) : 32'(LIM_CYC);
    endfunction : exp_width
    task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
        samples_checked++;
        if (got_v !== exp_v) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask : check
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    // Frame tick tracking and pin monitors
    always @(posedge ref_clk) begin
        bc_q <= bit_clock_in;
        if (bit_clock_in && !bc_q) begin
            tk <= (tk > 200 && !host_tx_in) ? 0 : (tk < 250 ? tk + 1 : tk);
            rk <= (rk > 200 && !ir_pulse_in) ? 0 : (rk < 250 ? rk + 1 : rk);
            if (rk < 159 && rk % 16 == 11) rgot[rk / 16] <= host_rx_out;
        end
        if (ir_pulse_out === 1'b1) begin
            if (hi == 0) begin
                check(tk % 16, 7);
                got[tk / 16] <= 1'b0;
            end
            hi <= hi + 1;
        end else begin
            if (hi != 0 && rst_n) check(hi, exp_width(far_inst.half));
            hi <= 0;
        end
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 80000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic run_byte(input logic [7:0] tx_b, input logic [7:0] ir_b);
        got  = 16'hffff;
        rgot = 16'hffff;
        fork
            far_inst.send_host(tx_b);
            far_inst.send_ir(ir_b);
        join
        repeat (45) @(posedge bit_clock_in);
        check({22'h0, got[9:0]}, exp_frame(tx_b));
        check({22'h0, rgot[9:0]}, exp_frame(ir_b));
    endtask : run_byte
    initial begin
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        run_byte(8'h00, 8'hff);
        run_byte(8'hff, 8'h00);
        run_byte(8'h55, 8'haa);
        $display("test corners done");
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            run_byte(seed[7:0], seed[15:8]);
        end
        $display("test random done");
        fork
            run_byte(8'h3c, 8'hc3);
            begin
                repeat (300) @(negedge ref_clk);
                rst_n = 1'b0;
                repeat (3) @(negedge ref_clk);
                rst_n = 1'b1;
            end
        join
        $display("test glitch done");
        far_inst.half = 40;
        run_byte(8'h00, seed[23:16]);
        far_inst.half = 7;
        $display("test slow done");
        fork
            far_inst.send_host(8'h00);
            begin
                repeat (9) @(posedge bit_clock_in);
                @(negedge ref_clk);
                rst_n = 1'b0;
                repeat (6) @(negedge ref_clk);
                check({31'h0, host_rx_out}, 32'h1);
                check({31'h0, ir_pulse_out}, 32'h0);
            end
        join
        repeat (45) @(posedge bit_clock_in);
        @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        run_byte(8'h81, 8'h7e);
        $display("test reset done");
        close_out();
    end
endmodule : tb_top
bind uirc_codec uirc_codec_asserts uirc_codec_asserts_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .bit_clock_in(bit_clock_in), .host_tx_in(host_tx_in),
    .host_rx_out(host_rx_out), .ir_pulse_in(ir_pulse_in), .ir_pulse_out(ir_pulse_out));
`default_nettype wire

/* tb/uirc_codec_asserts.sv */
// Pin-level assertion checker for the UART / infrared pulse codec.
// Assumes a bind to uirc_codec; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module uirc_codec_asserts (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bit clock and data pins
    input wire logic bit_clock_in,
    input wire logic host_tx_in,
    input wire logic host_rx_out,
    input wire logic ir_pulse_in,
    input wire logic ir_pulse_out
);
    import uirc_pkg::*;
    logic       bc_q   = 1'b0;
    logic [7:0] ec     = 8'hff;
    logic [7:0] dc     = 8'hff;
    logic [7:0] txq    = 8'hff;
    logic [7:0] rxq    = 8'hff;
    logic [7:0] hi_cnt = 8'h00;
    wire logic  tick   = bit_clock_in && !bc_q;
    // Frame tick counts, quiet tick counts, pulse length
    always @(posedge ref_clk) begin
        bc_q <= bit_clock_in;
        hi_cnt <= ir_pulse_out ? hi_cnt + 8'h01 : 8'h00;
        if (tick) begin
            ec <= (ec > 8'hc8 && !host_tx_in) ? 8'h00 : ec + 8'(ec != 8'hff);
            dc <= (dc > 8'hc8 && !ir_pulse_in) ? 8'h00 : dc + 8'(dc != 8'hff);
            txq <= !host_tx_in ? 8'h00 : txq + 8'(txq != 8'hff);
            rxq <= !ir_pulse_in ? 8'h00 : rxq + 8'(rxq != 8'hff);
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_reset_levels: assert property (disable iff (1'b0) !rst_n [*7] |-> host_rx_out && !ir_pulse_out)
        else $error("outputs not at reset levels");
    a_tx_lead_seven: assert property (ec == 8'h07 && $past(ec) == 8'h06 |-> $rose(ir_pulse_out))
        else $error("pulse not after seventh tick");
    a_rx_lead_four: assert property (dc == 8'h04 && $past(dc) == 8'h03 |-> $fell(host_rx_out))
        else $error("host output not low after fourth tick");
    a_pulse_limit: assert property (ir_pulse_out |-> hi_cnt < 8'(LIM_CYC))
        else $error("pulse longer than limiter");
    a_tx_idle_low: assert property (txq > 8'h10 |-> !ir_pulse_out)
        else $error("pulse while host line idle");
    a_rx_idle_high: assert property (rxq > 8'h15 |-> host_rx_out)
        else $error("host output low while line idle");
    a_ir_rise_tick: assert property ($rose(ir_pulse_out) |-> $past(tick))
        else $error("pulse rise not tied to tick");
    a_rx_edge_tick: assert property ($changed(host_rx_out) |-> $past(tick))
        else $error("host output edge not tied to tick");
    c_tx_frame: cover property (ec == 8'h07);
    c_rx_frame: cover property (dc == 8'h04);
    c_limiter: cover property (hi_cnt == 8'(LIM_CYC - 1));
endmodule : uirc_codec_asserts
`default_nettype wire

/* tb/uirc_far.sv */
// Far-side model: bit clock source, host UART and infrared transceiver.
// Assumes the bench changes half only between bytes.
`timescale 1ns/1ps
`default_nettype none
module uirc_far (
    // System clock
    input  wire logic ref_clk,
    // Pins toward the codec
    output logic      bit_clock_in,
    output logic      host_tx_in,
    output logic      ir_pulse_in
);
    int half = 7;
    int cnt  = 0;
    initial begin
        bit_clock_in = 1'b0;
        host_tx_in   = 1'b1;
        ir_pulse_in  = 1'b1;
    end
    // Bit clock, half period in ref_clk cycles
    always @(negedge ref_clk) begin
        if (cnt >= half - 1) begin
            cnt = 0;
            bit_clock_in <= !bit_clock_in;
        end else cnt++;
    end
    // Host UART frame, bits change between ticks
    task automatic send_host(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        @(negedge bit_clock_in);
        for (int i = 0; i < 10; i++) begin
            host_tx_in = f[i];
            repeat (i == 0 ? 15 : 16) @(negedge bit_clock_in);
        end
    endtask : send_host
    // Transceiver frame: a zero is low for three ticks
    task automatic send_ir(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        @(negedge bit_clock_in);
        for (int i = 0; i < 10; i++) begin
            ir_pulse_in = f[i];
            repeat (3) @(negedge bit_clock_in);
            ir_pulse_in = 1'b1;
            repeat (13) @(negedge bit_clock_in);
        end
    endtask : send_ir
endmodule : uirc_far
`default_nettype wire
